// *** logic/bhp_function_block.sv ***
// Function block with block-level and port-level handshakes.
// Assumes the far parties are logic on the same clock.
//
// Behaviour
// [R1] Full handshake: start only on launch request
// [R2] Completion marks end and valid return value
// [R3] Quiescent flag high whenever not processing
// [R4] Accept-next flag shows input can be taken
// [R5] No-handshake mode: control ports stay inactive (quiescentFlag still goes high in ST_IDLE)
// [R6] Chained mode adds downstream continue input
// [R7] Continue low: finish, complete, then halt
// [R8] Default modes: plain in, valid out, RAM
// [R9] Plain port: data without handshake signals
// [R10] Stable input held constant between resets
// [R11] Valid input read stalls until valid
// [R12] Valid output asserted when data written
// [R13] Ack: read pulses ack, write waits ack
// [R14] Full handshake: valid/ack both directions
// [R15] Optional valid: plain in, valid out
// [R16] External RAM via data, address, enables
// [R17] FIFO input: read strobe, stall on empty
// [R18] FIFO output: write strobe, stall on full
// [R19] Bus mode: FIFO-style burst with address
// [R20] Registering holds data and protocol signals
// [R21] Registering needs full handshake; return registered
// [R22] Registered outputs held until execution ends
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module bhp_function_block #(
  parameter int DATA_W = 32,
  parameter int RAM_AW = 8
) (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_b, // Async reset
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic launchRequest, // Start invocation
  output logic completionFlag, // Invocation done
  output logic quiescentFlag, // Not processing
  output logic acceptNextFlag, // Input taken
  input wire logic downstreamContinue, // Chain continue
  output logic [DATA_W-1:0] returnValue, // Return value
  input wire logic [DATA_W-1:0] coefIn, // Stable argument
  input wire logic [DATA_W-1:0] inData, // Input argument
  input wire logic inValid, // Input valid
  output logic inAck, // Input acknowledge
  output logic inRead, // FIFO read strobe
  input wire logic inEmptyN, // FIFO not empty
  output logic [DATA_W-1:0] outData, // Output argument
  output logic outValid, // Output valid
  input wire logic outAckIn, // Output acknowledge
  output logic outWrite, // FIFO write strobe
  input wire logic outFullN, // FIFO not full
  output logic [RAM_AW-1:0] busAddr, // Burst bus address
  output logic [RAM_AW-1:0] ramAddr, // RAM address
  output logic ramCe, // RAM chip enable
  output logic ramWe, // RAM write enable
  output logic [DATA_W-1:0] ramWdata, // RAM write data
  input wire logic [DATA_W-1:0] ramRdata // RAM read data
);
  import bhp_pkg::*;

  bhp_state_type state_q;
  bhp_state_type state_d;
  bhp_func_mode_type funcMode_q;
  bhp_port_mode_type inMode_q;
  bhp_port_mode_type outMode_q;
  logic regEn_q;
  logic regActive;
  logic [DATA_W-1:0] inLatch_q;
  logic [DATA_W-1:0] result_q;
  logic [RAM_AW-1:0] ramAddr_q;
  logic [31:0] count_q;
  logic holdValid_q;
  logic busAck_q;
  logic [31:0] rdNext;
  logic inTake;
  logic outDone;
  logic startNow;
  logic chainHold;
  logic inIsFifo;
  logic outIsFifo;
  logic outHasValid;

  // Registering only counts with a handshake present
  // [R21] registering needs handshake
  assign regActive = regEn_q && (funcMode_q != NO_FUNCTION_HANDSHAKE);

  assign inIsFifo = (inMode_q == FIFO_ACCESS_PORT) ||
    (inMode_q == BURST_BUS_PORT);
  assign outIsFifo = (outMode_q == FIFO_ACCESS_PORT) ||
    (outMode_q == BURST_BUS_PORT);
  assign outHasValid = (outMode_q == VALID_ONLY_PORT) ||
    (outMode_q == OPTIONAL_VALID_PORT) ||
    (outMode_q == FULL_PORT_HANDSHAKE);

  // Input take condition per port mode
  always_comb
  begin
    case (inMode_q)
      // [R11] valid input stalls
      VALID_ONLY_PORT: inTake = inValid;
      // [R14] wait valid then ack
      FULL_PORT_HANDSHAKE: inTake = inValid;
      // [R17] fifo input stalls empty
      FIFO_ACCESS_PORT: inTake = inEmptyN;
      BURST_BUS_PORT: inTake = inEmptyN;
      // [R9] plain wire taken directly
      default: inTake = 1'b1;
    endcase
  end

  // Output completion condition per port mode
  always_comb
  begin
    case (outMode_q)
      // [R13] write waits for ack
      ACKNOWLEDGE_ONLY_PORT: outDone = outAckIn;
      FULL_PORT_HANDSHAKE: outDone = outAckIn;
      // [R18] fifo output stalls full
      FIFO_ACCESS_PORT: outDone = outFullN;
      BURST_BUS_PORT: outDone = outFullN;
      default: outDone = 1'b1;
    endcase
  end

  // [R1] launch gates start
  assign startNow = (funcMode_q == NO_FUNCTION_HANDSHAKE) || launchRequest;
  // [R6] [R7] hold done until continue
  assign chainHold = (funcMode_q == CHAINED_FUNCTION_HANDSHAKE) &&
    !downstreamContinue;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (startNow) state_d = ST_READ;
      ST_READ: if (inTake) state_d = ST_MEMRD;
      ST_MEMRD: state_d = ST_MEMWAIT;
      ST_MEMWAIT: state_d = ST_WRITE;
      ST_WRITE: if (outDone) state_d = ST_DONE;
      ST_DONE: if (!chainHold) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Function-level control outputs
  // [R3] idle while not processing
  assign quiescentFlag = (state_q == ST_IDLE);
  // [R2] completion; [R5] none in no-handshake mode
  assign completionFlag = (state_q == ST_DONE) &&
    (funcMode_q != NO_FUNCTION_HANDSHAKE);
  // [R4] ready for next input
  assign acceptNextFlag = (state_q == ST_READ) && inTake &&
    (funcMode_q != NO_FUNCTION_HANDSHAKE);

  // Input port strobes
  // [R13] read pulses ack
  assign inAck = (state_q == ST_READ) && inTake &&
    ((inMode_q == ACKNOWLEDGE_ONLY_PORT) ||
    (inMode_q == FULL_PORT_HANDSHAKE));
  // [R17] read strobe while wanting data
  assign inRead = (state_q == ST_READ) && inIsFifo;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      inLatch_q <= '0;
    else if (state_q == ST_READ && inTake)
      inLatch_q <= inData;
  end

  // [R10] stable input used as a plain wire
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      result_q <= '0;
    else if (state_q == ST_MEMWAIT)
      result_q <= inLatch_q + ramRdata + coefIn;
  end

  // [R2] return valid with completion; [R21] registered
  assign returnValue = result_q;
  assign outData = result_q;

  // Output port strobes
  // [R12] valid with write; [R15] optional valid
  assign outValid = ((state_q == ST_WRITE) && outHasValid) || holdValid_q;
  // [R18] write strobe when space
  assign outWrite = (state_q == ST_WRITE) && outIsFifo && outFullN;

  // [R20] hold valid to end; [R22] until execution ends
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      holdValid_q <= 1'b0;
    else if (state_q == ST_WRITE && outDone && regActive && outHasValid)
      holdValid_q <= 1'b1;
    else if (state_q == ST_DONE && !chainHold)
      holdValid_q <= 1'b0;
  end

  // [R16] external RAM read then write back
  assign ramAddr = ramAddr_q;
  assign ramCe = (state_q == ST_MEMRD) || (state_q == ST_DONE &&
    !chainHold);
  assign ramWe = (state_q == ST_DONE) && !chainHold;
  assign ramWdata = result_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ramAddr_q <= '0;
    else if (ramWe)
      ramAddr_q <= ramAddr_q + 1'b1;
  end

  // [R19] burst address advances per bus beat
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busAddr <= '0;
    else if ((inRead && inEmptyN && inMode_q == BURST_BUS_PORT) ||
      (outWrite && outMode_q == BURST_BUS_PORT))
      busAddr <= busAddr + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= '0;
    else if (state_q == ST_DONE && !chainHold)
      count_q <= count_q + 32'h00000001;
  end

  // Avalon slave: one wait cycle per request
  assign avs_waitrequest = (avs_read || avs_write) && !busAck_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busAck_q <= 1'b0;
    else
      busAck_q <= (avs_read || avs_write) && !busAck_q;
  end

  // [R8] default modes at reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      funcMode_q <= FUNC_RESET;
      inMode_q <= IN_RESET;
      outMode_q <= OUT_RESET;
      regEn_q <= REG_RESET;
    end
    else if (avs_write && busAck_q && avs_address == ADDR_CONFIG)
    begin
      if (avs_byteenable[0])
      begin
        funcMode_q <= bhp_func_mode_type'(avs_writedata[CFG_FUNC_LSB+:2]);
        inMode_q <= bhp_port_mode_type'(avs_writedata[CFG_IN_LSB+:4]);
      end
      if (avs_byteenable[0] && avs_byteenable[1])
        outMode_q <= bhp_port_mode_type'(avs_writedata[CFG_OUT_LSB+:4]);
      if (avs_byteenable[1])
        regEn_q <= avs_writedata[CFG_REG_BIT];
    end
  end

  always_comb
  begin
    rdNext = 32'h00000000;
    case (avs_address)
      ADDR_CONFIG:
      begin
        rdNext[CFG_FUNC_LSB+:2] = funcMode_q;
        rdNext[CFG_IN_LSB+:4] = inMode_q;
        rdNext[CFG_OUT_LSB+:4] = outMode_q;
        rdNext[CFG_REG_BIT] = regEn_q;
      end
      ADDR_STATUS:
      begin
        rdNext[STS_QUIET_BIT] = quiescentFlag;
        rdNext[STS_DONE_BIT] = completionFlag;
        rdNext[STS_STATE_LSB+:6] = state_q;
      end
      ADDR_RETURN: rdNext = 32'(result_q);
      ADDR_COUNT: rdNext = count_q;
      default: rdNext = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !busAck_q)
      avs_readdata <= rdNext;
  end

  // Checks
  property p_launch;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_IDLE && funcMode_q != NO_FUNCTION_HANDSHAKE &&
      !launchRequest) |=> quiescentFlag;
  endproperty
  a_launch: assert property (p_launch) // [R1]
    else $error("started without launch");

  property p_done;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_WRITE && outDone &&
      funcMode_q != NO_FUNCTION_HANDSHAKE) |=> completionFlag;
  endproperty
  a_done: assert property (p_done) // [R2]
    else $error("completion missing after write");

  property p_idle;
    @(posedge clk) disable iff (!rst_b)
    (quiescentFlag && launchRequest) |=> !quiescentFlag ##3 !quiescentFlag;
  endproperty
  a_idle: assert property (p_idle) // [R3]
    else $error("idle during invocation");

  property p_none;
    @(posedge clk) disable iff (!rst_b)
    (funcMode_q == NO_FUNCTION_HANDSHAKE) |->
      !completionFlag && !acceptNextFlag;
  endproperty
  a_none: assert property (p_none) // [R5]
    else $error("control active in no-handshake mode");

  property p_chain;
    @(posedge clk) disable iff (!rst_b)
    (completionFlag && funcMode_q == CHAINED_FUNCTION_HANDSHAKE &&
      !downstreamContinue) |=> completionFlag && $stable(result_q);
  endproperty
  a_chain: assert property (p_chain) // [R7]
    else $error("proceeded without continue");

  property p_vldstall;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_READ && !inValid && (inMode_q == VALID_ONLY_PORT ||
      inMode_q == FULL_PORT_HANDSHAKE)) |=> state_q == ST_READ;
  endproperty
  a_vldstall: assert property (p_vldstall) // [R11] [R14]
    else $error("read passed without valid");

  property p_outvld;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_WRITE && outMode_q == VALID_ONLY_PORT) |->
      outValid ##1 (state_q == ST_DONE);
  endproperty
  a_outvld: assert property (p_outvld) // [R12]
    else $error("valid output not with write");

  property p_ack;
    @(posedge clk) disable iff (!rst_b)
    inAck |=> !inAck;
  endproperty
  a_ack: assert property (p_ack) // [R13]
    else $error("input ack longer than a pulse");

  property p_fifoin;
    @(posedge clk) disable iff (!rst_b)
    (inRead && !inEmptyN) |=> inRead;
  endproperty
  a_fifoin: assert property (p_fifoin) // [R17]
    else $error("fifo read left while empty");

  property p_fifoout;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_WRITE && outIsFifo && !outFullN) |=>
      state_q == ST_WRITE;
  endproperty
  a_fifoout: assert property (p_fifoout) // [R18]
    else $error("fifo write left while full");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ST_WRITE && outDone && regActive &&
      outMode_q == VALID_ONLY_PORT) |=> outValid && completionFlag;
  endproperty
  a_hold: assert property (p_hold) // [R20]
    else $error("registered valid not held");

endmodule

// *** logic/bhp_pkg.sv ***
// Package for the block handshake port wrapper.
// Assumes one clock; register map reached over Avalon-MM.
package bhp_pkg;

  // Register byte offsets
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RETURN = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;

  // Config field positions
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_IN_LSB = 2;
  localparam int CFG_OUT_LSB = 6;
  localparam int CFG_REG_BIT = 10;

  // Status field positions
  localparam int STS_QUIET_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_STATE_LSB = 2;

  typedef enum logic [1:0] {
    NO_FUNCTION_HANDSHAKE = 2'h0,
    FULL_FUNCTION_HANDSHAKE = 2'h1,
    CHAINED_FUNCTION_HANDSHAKE = 2'h2
  } bhp_func_mode_type;

  typedef enum logic [3:0] {
    PLAIN_WIRE_PORT = 4'h0,
    RESET_STABLE_PORT = 4'h1,
    VALID_ONLY_PORT = 4'h2,
    ACKNOWLEDGE_ONLY_PORT = 4'h3,
    FULL_PORT_HANDSHAKE = 4'h4,
    OPTIONAL_VALID_PORT = 4'h5,
    FIFO_ACCESS_PORT = 4'h6,
    BURST_BUS_PORT = 4'h7
  } bhp_port_mode_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_READ = 6'h02,
    ST_MEMRD = 6'h04,
    ST_MEMWAIT = 6'h08,
    ST_WRITE = 6'h10,
    ST_DONE = 6'h20
  } bhp_state_type;

  // Reset values: full handshake, inputs plain, outputs valid
  localparam bhp_func_mode_type FUNC_RESET = FULL_FUNCTION_HANDSHAKE;
  localparam bhp_port_mode_type IN_RESET = PLAIN_WIRE_PORT;
  localparam bhp_port_mode_type OUT_RESET = VALID_ONLY_PORT;
  localparam logic REG_RESET = 1'b0;

endpackage

// *** testbench/bhp_far_model.sv ***
// Far-side model: RAM, input source and output sink.
// Assumes the block's clock; the bench sets the stall inputs.
`timescale 1ns/1ps
module bhp_far_model (
  input wire logic clk, // Shared clock
  input wire logic inStall, // Hold input back
  input wire logic outStall, // Hold output back
  input wire logic [31:0] srcData, // Next input value
  output logic [31:0] inData, // Input argument
  output logic inValid, // Input valid
  output logic inEmptyN, // Source not empty
  output logic outAckIn, // Output acknowledge
  output logic outFullN, // Sink not full
  input wire logic [7:0] ramAddr, // RAM address
  input wire logic ramCe, // RAM chip enable
  input wire logic ramWe, // RAM write enable
  input wire logic [31:0] ramWdata, // RAM write data
  output logic [31:0] ramRdata // RAM read data
);
  logic [31:0] mem [256];
  logic [31:0] rdQ = 32'h0;
  logic rdValid = 1'b0;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 32'hA5A50000 + i;
  end
  assign inValid = !inStall;
  assign inEmptyN = !inStall;
  assign inData = inStall ? ~srcData : srcData;
  assign outAckIn = !outStall;
  assign outFullN = !outStall;
  // Read data one cycle after enable
  always @(posedge clk)
  begin
    rdValid <= ramCe && !ramWe;
    if (ramCe && ramWe)
      mem[ramAddr] <= ramWdata;
    if (ramCe && !ramWe)
      rdQ <= mem[ramAddr];
  end
  assign ramRdata = rdValid ? rdQ : ~rdQ;
endmodule

// *** testbench/bhp_function_block_tb_top.sv ***
// Self-checking bench for the handshake function block.
// Assumes default widths and the far model beside the block.
`timescale 1ns/1ps
module bhp_function_block_tb_top;
  import bhp_pkg::*;
  typedef struct {
    bhp_port_mode_type mode;
    logic [31:0] data;
    logic [4:0] strobes;
  } bhp_row_type;
  bhp_row_type rows [8] = '{
    '{PLAIN_WIRE_PORT, 32'h00000011, 5'h10},
    '{RESET_STABLE_PORT, 32'h00000022, 5'h10},
    '{VALID_ONLY_PORT, 32'h00000033, 5'h14},
    '{ACKNOWLEDGE_ONLY_PORT, 32'h00000044, 5'h11},
    '{FULL_PORT_HANDSHAKE, 32'h00000055, 5'h15},
    '{OPTIONAL_VALID_PORT, 32'h00000066, 5'h14},
    '{FIFO_ACCESS_PORT, 32'h00000077, 5'h1A},
    '{BURST_BUS_PORT, 32'hFFFFFF88, 5'h1A}};
  logic clk = 0;
  logic rst_b = 0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, returnValue, inData, outData, ramWdata, ramRdata;
  logic avs_waitrequest, completionFlag, quiescentFlag, acceptNextFlag;
  logic launchRequest = 0;
  logic downstreamContinue = 1;
  logic [31:0] coef = 32'h00000100;
  logic [31:0] srcData = 32'h0;
  logic inStall = 0;
  logic outStall = 0;
  logic inValid, inAck, inRead, inEmptyN, outValid, outAckIn, outWrite;
  logic outFullN, ramCe, ramWe;
  logic [7:0] busAddr, ramAddr;
  logic [7:0] k = 8'h0;
  logic [5:0] evSig;
  int evCnt [6] = '{default: 0};
  int failures = 0;
  int compares = 0;
  always #50 clk = ~clk;
  bhp_function_block bhp_function_block_i (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .launchRequest(launchRequest), .completionFlag(completionFlag),
    .quiescentFlag(quiescentFlag), .acceptNextFlag(acceptNextFlag),
    .downstreamContinue(downstreamContinue), .returnValue(returnValue),
    .coefIn(coef), .inData(inData), .inValid(inValid), .inAck(inAck),
    .inRead(inRead), .inEmptyN(inEmptyN), .outData(outData),
    .outValid(outValid), .outAckIn(outAckIn), .outWrite(outWrite),
    .outFullN(outFullN), .busAddr(busAddr), .ramAddr(ramAddr),
    .ramCe(ramCe), .ramWe(ramWe), .ramWdata(ramWdata),
    .ramRdata(ramRdata));
  bhp_far_model far_i (.clk(clk), .inStall(inStall), .outStall(outStall),
    .srcData(srcData), .inData(inData), .inValid(inValid),
    .inEmptyN(inEmptyN), .outAckIn(outAckIn), .outFullN(outFullN),
    .ramAddr(ramAddr), .ramCe(ramCe), .ramWe(ramWe),
    .ramWdata(ramWdata), .ramRdata(ramRdata));
  // Strobe counters: ack, read, valid, write, accept, completion
  assign evSig = {completionFlag, acceptNextFlag, outWrite, outValid,
    inRead, inAck};
  always @(posedge clk)
  begin
    for (int i = 0; i < 6; i++)
      if (evSig[i] === 1'b1)
        evCnt[i] <= evCnt[i] + 1;
  end
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic giveUp;
    failures++;
    print_verdict;
  endtask
  task automatic checkWord(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic checkBit(input string nm, input logic e, input logic g);
    checkWord(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic avAccess(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      giveUp;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic setCfg(input bhp_func_mode_type f,
    input bhp_port_mode_type i, input bhp_port_mode_type o, input logic r);
    logic [31:0] q;
    avAccess(1'b1, ADDR_CONFIG, {21'h0, r, o, i, f}, q);
  endtask
  task automatic waitHigh(input int s);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((s == 0 ? completionFlag : quiescentFlag) !== 1'b1 && n < 200);
    if (n >= 200)
      giveUp;
  endtask
  task automatic launch(input logic [31:0] d);
    @(posedge clk);
    srcData <= d;
    launchRequest <= 1'b1;
    @(posedge clk);
    launchRequest <= 1'b0;
  endtask
  task automatic finishRun(input logic [31:0] d);
    logic [31:0] e, q;
    e = d + 32'hA5A50000 + {24'h0, k} + coef;
    checkWord("returnValue", e, returnValue);
    checkWord("outData", e, outData);
    waitHigh(1);
    checkWord("ramBack", e, far_i.mem[k]);
    avAccess(1'b0, ADDR_RETURN, 32'h0, q);
    checkWord("returnReg", e, q);
    k++;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    giveUp;
  end
  initial
  begin
    logic [31:0] q;
    int snap [6];
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    avAccess(1'b0, ADDR_CONFIG, 32'h0, q);
    checkWord("config", 32'h00000081, q);
    avAccess(1'b1, ADDR_STATUS, 32'hFFFFFFFF, q);
    avAccess(1'b0, ADDR_STATUS, 32'h0, q);
    checkWord("status", 32'h00000005, q);
    avAccess(1'b0, 4'h2, 32'h0, q);
    checkWord("unmapped", 32'h0, q);
    repeat (10) @(negedge clk);
    checkWord("noLaunch", 0, evCnt[5]);
    checkBit("quiescentFlag", 1'b1, quiescentFlag);
    $display("test reset done");
    foreach (rows[i])
    begin
      setCfg(FULL_FUNCTION_HANDSHAKE, rows[i].mode, rows[i].mode, 1'b0);
      snap = evCnt;
      launch(rows[i].data);
      waitHigh(0);
      finishRun(rows[i].data);
      for (int j = 0; j < 5; j++)
        checkBit("strobe", rows[i].strobes[j],
          evCnt[j] != snap[j]);
      checkWord("acceptCount", 1, evCnt[4] - snap[4]);
      $display("test row %0d done", i);
    end
    avAccess(1'b0, ADDR_COUNT, 32'h0, q);
    checkWord("count", 32'h8, q);
    checkWord("busAddr", 32'h2, {24'h0, busAddr});
    for (int m = 0; m < 2; m++)
    begin
      setCfg(FULL_FUNCTION_HANDSHAKE, m ? FIFO_ACCESS_PORT :
        FULL_PORT_HANDSHAKE, m ? FIFO_ACCESS_PORT : FULL_PORT_HANDSHAKE, 1'b0);
      inStall <= 1'b1;
      outStall <= 1'b1;
      snap = evCnt;
      launch(32'h5A5A0000 + m);
      repeat (10) @(negedge clk);
      checkWord("acceptStalled", 0, evCnt[4] - snap[4]);
      checkBit("inRead", m[0], inRead);
      checkBit("quiescentFlag", 1'b0, quiescentFlag);
      @(posedge clk);
      inStall <= 1'b0;
      repeat (10) @(negedge clk);
      checkBit("doneStalled", 1'b0, completionFlag);
      checkBit("outValid", !m[0], outValid);
      checkWord("writeStalled", 0, evCnt[3] - snap[3]);
      @(posedge clk);
      outStall <= 1'b0;
      waitHigh(0);
      finishRun(32'h5A5A0000 + m);
      $display("test stall %0d done", m);
    end
    setCfg(FULL_FUNCTION_HANDSHAKE, PLAIN_WIRE_PORT, VALID_ONLY_PORT, 1'b1);
    launch(32'h0BAD0001);
    waitHigh(0);
    checkBit("outValidHeld", 1'b1, outValid);
    finishRun(32'h0BAD0001);
    $display("test register done");
    setCfg(CHAINED_FUNCTION_HANDSHAKE, PLAIN_WIRE_PORT, VALID_ONLY_PORT, 1'b0);
    downstreamContinue <= 1'b0;
    launch(32'h00C0FFEE);
    waitHigh(0);
    repeat (5) @(negedge clk);
    checkBit("doneHeld", 1'b1, completionFlag);
    checkBit("quiescentFlag", 1'b0, quiescentFlag);
    @(posedge clk);
    downstreamContinue <= 1'b1;
    finishRun(32'h00C0FFEE);
    $display("test chain done");
    setCfg(NO_FUNCTION_HANDSHAKE, PLAIN_WIRE_PORT, VALID_ONLY_PORT, 1'b0);
    snap = evCnt;
    repeat (30) @(negedge clk);
    checkWord("noneDone", 0, evCnt[5] - snap[5]);
    checkWord("noneAccept", 0, evCnt[4] - snap[4]);
    checkBit("noneRuns", 1'b1, evCnt[2] != snap[2]);
    $display("test none done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(negedge clk);
    checkBit("rstQuiet", 1'b1, quiescentFlag);
    @(posedge clk);
    rst_b <= 1'b1;
    avAccess(1'b0, ADDR_CONFIG, 32'h0, q);
    checkWord("rstConfig", 32'h00000081, q);
    $display("test mid reset done");
    print_verdict;
  end
endmodule
